// [src/mpe_motor_pwm.sv]
// Motor PWM generator with periodic back-voltage sampling and PI gain decoding.
// What this block does
// - Nonzero reference is absolute full-throttle motor voltage in tenths of a volt.
// - Reference zero, the reset value, follows the track supply voltage.
// - Absolute mode drives speed fraction of reference whenever the supply is at least that high.
// - High-frequency PWM is 20 kHz, or 40 kHz with special bit 5 set.
// - Drive is suspended 50 to 200 times per second for back-voltage sampling.
// - Default sampling rate falls from 200 Hz at standstill to 50 Hz at top.
// - Sampling setting 55, the reset value, is high frequency, medium rate and time.
// - Tens digit 1-4 lowers, 6-9 raises the sampling rate.
// - Ones digit 1-4 shortens, 6-9 lengthen the sampling time.
// - Settings 178-255 give low-frequency PWM of period (131+4m) shifted by e.
// - PI setting 55, the reset value, gives medium gains with automatic tuning.
// - PI settings 0-99 suit ordinary motors, 100-199 coreless motors.
// - PI tens digit lowers (1-4) or raises (6-9) proportional gain.
// - PI ones digit lowers (1-4) or raises (6-9) integral gain.
// - Extended sampling time, reset zero, lengthens the measurement window.
`timescale 1ns/10ps
module mpe_motor_pwm #(
    parameter int unsigned SAMP_FAST_CYC = mpe_pkg::SAMP_FAST_CYC,
    parameter int unsigned SAMP_SLOW_CYC = mpe_pkg::SAMP_SLOW_CYC
) (
    input wire logic sys_clk_i,
    input wire logic rst_n_i,
    input wire logic [2:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [7:0] reg_rdata_o,
    input wire logic [7:0] speed_i,
    input wire logic [7:0] supply_volt_i,
    input wire logic [7:0] motor_back_voltage_i,
    output logic motor_pwm_o,
    output logic sample_window_o,
    output logic [7:0] motor_back_voltage_o,
    output logic sample_valid_o,
    output logic [3:0] p_gain_o,
    output logic [3:0] i_gain_o,
    output logic coreless_o,
    output logic auto_tune_o
);

    // ----------------------------------------------------------------
    // Register file
    // ----------------------------------------------------------------
    mpe_pkg::mpe_cfg_s cfg_r;
    mpe_pkg::mpe_cfg_s cfg_nxt;
    logic [7:0] rdata_r;
    logic [7:0] rdata_nxt;
    logic [7:0] back_volt_r;
    logic [7:0] back_volt_nxt;
    mpe_pkg::mpe_state_e state_r;
    mpe_pkg::mpe_state_e state_nxt;
    logic pwm_r;

    always_comb
    begin
        cfg_nxt = cfg_r;
        rdata_nxt = 8'h00;
        if (reg_wr_i)
        begin
            case (reg_addr_i)
                mpe_pkg::IDX_VOLT_REF: cfg_nxt.volt_ref = reg_wdata_i;
                mpe_pkg::IDX_SAMP_CFG: cfg_nxt.samp_cfg = reg_wdata_i;
                mpe_pkg::IDX_SPECIAL: cfg_nxt.special = reg_wdata_i;
                mpe_pkg::IDX_PI_SET: cfg_nxt.pi_set = reg_wdata_i;
                mpe_pkg::IDX_EXT_TIME: cfg_nxt.ext_time = reg_wdata_i;
                default: cfg_nxt = cfg_r;
            endcase
        end
        if (reg_rd_i)
        begin
            case (reg_addr_i)
                mpe_pkg::IDX_VOLT_REF: rdata_nxt = cfg_r.volt_ref;
                mpe_pkg::IDX_SAMP_CFG: rdata_nxt = cfg_r.samp_cfg;
                mpe_pkg::IDX_SPECIAL: rdata_nxt = cfg_r.special;
                mpe_pkg::IDX_PI_SET: rdata_nxt = cfg_r.pi_set;
                mpe_pkg::IDX_EXT_TIME: rdata_nxt = cfg_r.ext_time;
                mpe_pkg::IDX_BACK_VOLT: rdata_nxt = back_volt_r;
                mpe_pkg::IDX_STATUS: rdata_nxt = {5'h00, pwm_r, state_r};
                default: rdata_nxt = 8'h00;
            endcase
        end
    end

    always_ff @(posedge sys_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            cfg_r.volt_ref <= mpe_pkg::RST_VOLT_REF;
            cfg_r.samp_cfg <= mpe_pkg::RST_SAMP_CFG;
            cfg_r.special <= mpe_pkg::RST_SPECIAL;
            cfg_r.pi_set <= mpe_pkg::RST_PI_SET;
            cfg_r.ext_time <= mpe_pkg::RST_EXT_TIME;
            rdata_r <= 8'h00;
        end
        else
        begin
            cfg_r <= cfg_nxt;
            rdata_r <= rdata_nxt;
        end
    end

    assign reg_rdata_o = rdata_r;

    // ----------------------------------------------------------------
    // Setting decode
    // ----------------------------------------------------------------
    logic lf_mode;
    logic digit_mode;
    logic [3:0] samp_tens;
    logic [3:0] samp_ones;
    logic [18:0] pwm_period;
    logic [4:0] lf_mant;
    logic [2:0] lf_exp;

    always_comb
    begin
        lf_mode = (cfg_r.samp_cfg >= mpe_pkg::LF_MIN_SETTING);
        digit_mode = (cfg_r.samp_cfg <= mpe_pkg::DIGIT_CODED_MAX);
        samp_tens = mpe_pkg::DIGIT_DEFAULT;
        samp_ones = mpe_pkg::DIGIT_DEFAULT;
        if (digit_mode)
        begin
            samp_tens = 4'(cfg_r.samp_cfg / 8'(mpe_pkg::DIGIT_SPAN));
            samp_ones = 4'(cfg_r.samp_cfg % 8'(mpe_pkg::DIGIT_SPAN));
        end
        lf_mant = cfg_r.samp_cfg[mpe_pkg::LF_MANT_MSB:0];
        lf_exp = cfg_r.samp_cfg[7:mpe_pkg::LF_EXP_LSB];
        if (lf_mode)
        begin
            // Period formula counts in microseconds, widened to clock cycles here.
            pwm_period = 19'(((mpe_pkg::LF_BASE + (19'(lf_mant) << mpe_pkg::LF_MANT_SHIFT))
                << lf_exp) * mpe_pkg::LF_UNIT_CYC);
        end
        else if (cfg_r.special[mpe_pkg::FREQ_SEL_BIT])
        begin
            pwm_period = mpe_pkg::HF_FAST_CYC;
        end
        else
        begin
            pwm_period = mpe_pkg::HF_SLOW_CYC;
        end
    end

    // ----------------------------------------------------------------
    // PWM duty and counter
    // ----------------------------------------------------------------
    logic [18:0] pwm_cnt_r;
    logic [18:0] pwm_cnt_nxt;
    logic pwm_nxt;
    logic [7:0] ref_eff;
    logic [39:0] duty_lhs;
    logic [39:0] duty_rhs;

    always_comb
    begin
        // Zero reference tracks the supply, which makes the duty simply speed over full scale.
        ref_eff = (cfg_r.volt_ref == 8'h00) ? supply_volt_i : cfg_r.volt_ref;
        // On while cnt/period < (speed/255)*(ref/supply); cross-multiplied to avoid a divider.
        duty_lhs = 40'(pwm_cnt_r) * 40'(supply_volt_i) * 40'(mpe_pkg::FULL_SCALE);
        duty_rhs = 40'(speed_i) * 40'(ref_eff) * 40'(pwm_period);
        pwm_cnt_nxt = pwm_cnt_r + 19'h00001;
        if (pwm_cnt_r >= pwm_period - 19'h00001)
        begin
            pwm_cnt_nxt = 19'h00000;
        end
        pwm_nxt = (supply_volt_i != 8'h00) && (duty_lhs < duty_rhs);
        if (state_nxt != mpe_pkg::ST_DRIVE)
        begin
            pwm_nxt = 1'b0;
        end
    end

    always_ff @(posedge sys_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            pwm_cnt_r <= 19'h00000;
            pwm_r <= 1'b0;
        end
        else
        begin
            pwm_cnt_r <= pwm_cnt_nxt;
            pwm_r <= pwm_nxt;
        end
    end

    assign motor_pwm_o = pwm_r;

    // ----------------------------------------------------------------
    // Sampling interval and window
    // ----------------------------------------------------------------
    localparam int unsigned SAMP_STEP = (SAMP_SLOW_CYC - SAMP_FAST_CYC) / int'(mpe_pkg::FULL_SCALE);
    logic [31:0] interval_base;
    logic [31:0] interval_len;
    logic [15:0] window_len;
    logic [31:0] int_cnt_r;
    logic [31:0] int_cnt_nxt;
    logic [15:0] win_cnt_r;
    logic [15:0] win_cnt_nxt;
    logic valid_r;
    logic valid_nxt;

    always_comb
    begin
        interval_base = 32'(SAMP_FAST_CYC) + 32'(speed_i) * 32'(SAMP_STEP);
        // Lower rate means a longer interval, so the tens digit is mirrored.
        interval_len = (interval_base * 32'(mpe_pkg::mpe_digit_scale(mpe_pkg::DIGIT_SPAN
            - samp_tens))) >> mpe_pkg::SCALE_SHIFT;
        if (interval_len < 32'(SAMP_FAST_CYC))
        begin
            interval_len = 32'(SAMP_FAST_CYC);
        end
        if (interval_len > 32'(SAMP_SLOW_CYC))
        begin
            interval_len = 32'(SAMP_SLOW_CYC);
        end
        window_len = 16'((32'(mpe_pkg::SAMP_TIME_CYC) * 32'(mpe_pkg::mpe_digit_scale(samp_ones)))
            >> mpe_pkg::SCALE_SHIFT) + 16'(cfg_r.ext_time) * mpe_pkg::EXT_UNIT_CYC;
        state_nxt = state_r;
        int_cnt_nxt = int_cnt_r;
        win_cnt_nxt = win_cnt_r;
        back_volt_nxt = back_volt_r;
        valid_nxt = 1'b0;
        case (state_r)
            mpe_pkg::ST_DRIVE:
            begin
                int_cnt_nxt = int_cnt_r + 32'h00000001;
                if (int_cnt_r >= interval_len - 32'h00000001)
                begin
                    int_cnt_nxt = 32'h00000000;
                    win_cnt_nxt = 16'h0000;
                    state_nxt = mpe_pkg::ST_SAMPLE;
                end
            end
            mpe_pkg::ST_SAMPLE:
            begin
                int_cnt_nxt = int_cnt_r + 32'h00000001;
                win_cnt_nxt = win_cnt_r + 16'h0001;
                if (win_cnt_r >= window_len - 16'h0001)
                begin
                    // Capture at the window end, when the motor voltage has settled the most.
                    back_volt_nxt = motor_back_voltage_i;
                    valid_nxt = 1'b1;
                    state_nxt = mpe_pkg::ST_DRIVE;
                end
            end
            default:
            begin
                state_nxt = mpe_pkg::ST_DRIVE;
            end
        endcase
    end

    always_ff @(posedge sys_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            state_r <= mpe_pkg::ST_DRIVE;
            int_cnt_r <= 32'h00000000;
            win_cnt_r <= 16'h0000;
            back_volt_r <= 8'h00;
            valid_r <= 1'b0;
        end
        else
        begin
            state_r <= state_nxt;
            int_cnt_r <= int_cnt_nxt;
            win_cnt_r <= win_cnt_nxt;
            back_volt_r <= back_volt_nxt;
            valid_r <= valid_nxt;
        end
    end

    assign sample_window_o = (state_r == mpe_pkg::ST_SAMPLE);
    assign motor_back_voltage_o = back_volt_r;
    assign sample_valid_o = valid_r;

    // ----------------------------------------------------------------
    // PI gain decode
    // ----------------------------------------------------------------
    logic [3:0] p_gain_r;
    logic [3:0] p_gain_nxt;
    logic [3:0] i_gain_r;
    logic [3:0] i_gain_nxt;
    logic coreless_r;
    logic coreless_nxt;
    logic auto_r;
    logic auto_nxt;
    logic [7:0] pi_low;

    always_comb
    begin
        // Settings above the coreless range are treated as the medium default.
        coreless_nxt = (cfg_r.pi_set >= mpe_pkg::CORELESS_MIN)
            && (cfg_r.pi_set <= mpe_pkg::PI_MAX);
        pi_low = coreless_nxt ? cfg_r.pi_set - mpe_pkg::CORELESS_MIN : cfg_r.pi_set;
        if (cfg_r.pi_set > mpe_pkg::PI_MAX)
        begin
            pi_low = mpe_pkg::PI_AUTO_SETTING;
        end
        p_gain_nxt = 4'(pi_low / 8'(mpe_pkg::DIGIT_SPAN));
        i_gain_nxt = 4'(pi_low % 8'(mpe_pkg::DIGIT_SPAN));
        if (p_gain_nxt == 4'h0)
        begin
            p_gain_nxt = mpe_pkg::DIGIT_DEFAULT;
        end
        if (i_gain_nxt == 4'h0)
        begin
            i_gain_nxt = mpe_pkg::DIGIT_DEFAULT;
        end
        auto_nxt = (pi_low == mpe_pkg::PI_AUTO_SETTING);
    end

    always_ff @(posedge sys_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            p_gain_r <= mpe_pkg::DIGIT_DEFAULT;
            i_gain_r <= mpe_pkg::DIGIT_DEFAULT;
            coreless_r <= 1'b0;
            auto_r <= 1'b1;
        end
        else
        begin
            p_gain_r <= p_gain_nxt;
            i_gain_r <= i_gain_nxt;
            coreless_r <= coreless_nxt;
            auto_r <= auto_nxt;
        end
    end

    assign p_gain_o = p_gain_r;
    assign i_gain_o = i_gain_r;
    assign coreless_o = coreless_r;
    assign auto_tune_o = auto_r;

endmodule : mpe_motor_pwm

// [src/mpe_pkg.sv]
// Constants, register map and carrier types of the motor PWM and back-voltage sampling block.
package mpe_pkg;

    // ----------------------------------------------------------------
    // Clock and timing
    // ----------------------------------------------------------------
    localparam int unsigned SYS_CLK_HZ = 10_000_000;
    localparam int unsigned CLK_PERIOD_NS = 1_000_000_000 / SYS_CLK_HZ;
    localparam int unsigned HF_SLOW_HZ = 20_000;
    localparam int unsigned HF_FAST_HZ = 40_000;
    localparam logic [18:0] HF_SLOW_CYC = 19'(SYS_CLK_HZ / HF_SLOW_HZ);
    localparam logic [18:0] HF_FAST_CYC = 19'(SYS_CLK_HZ / HF_FAST_HZ);
    localparam int unsigned LF_UNIT_NS = 1_000;
    localparam logic [18:0] LF_UNIT_CYC = 19'(LF_UNIT_NS / CLK_PERIOD_NS);
    localparam logic [18:0] LF_BASE = 19'h00083;
    localparam int unsigned SAMP_FAST_HZ = 200;
    localparam int unsigned SAMP_SLOW_HZ = 50;
    localparam int unsigned SAMP_FAST_CYC = SYS_CLK_HZ / SAMP_FAST_HZ;
    localparam int unsigned SAMP_SLOW_CYC = SYS_CLK_HZ / SAMP_SLOW_HZ;
    localparam int unsigned SAMP_TIME_NS = 200_000;
    localparam logic [15:0] SAMP_TIME_CYC =
        16'((SAMP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam int unsigned EXT_UNIT_NS = 10_000;
    localparam logic [15:0] EXT_UNIT_CYC = 16'((EXT_UNIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

    // ----------------------------------------------------------------
    // Register map
    // ----------------------------------------------------------------
    localparam logic [2:0] IDX_VOLT_REF = 3'h0;
    localparam logic [2:0] IDX_SAMP_CFG = 3'h1;
    localparam logic [2:0] IDX_SPECIAL = 3'h2;
    localparam logic [2:0] IDX_PI_SET = 3'h3;
    localparam logic [2:0] IDX_EXT_TIME = 3'h4;
    localparam logic [2:0] IDX_BACK_VOLT = 3'h5;
    localparam logic [2:0] IDX_STATUS = 3'h6;
    localparam logic [7:0] RST_VOLT_REF = 8'h00;
    localparam logic [7:0] RST_SAMP_CFG = 8'h37;
    localparam logic [7:0] RST_SPECIAL = 8'h04;
    localparam logic [7:0] RST_PI_SET = 8'h37;
    localparam logic [7:0] RST_EXT_TIME = 8'h00;

    // ----------------------------------------------------------------
    // Fields and decoded ranges
    // ----------------------------------------------------------------
    localparam int unsigned FREQ_SEL_BIT = 5;
    localparam int unsigned LF_MANT_MSB = 4;
    localparam int unsigned LF_EXP_LSB = 5;
    localparam int unsigned LF_MANT_SHIFT = 2;
    localparam logic [7:0] LF_MIN_SETTING = 8'hB2;
    localparam logic [7:0] DIGIT_CODED_MAX = 8'h63;
    localparam logic [7:0] CORELESS_MIN = 8'h64;
    localparam logic [7:0] PI_MAX = 8'hC7;
    localparam logic [7:0] PI_AUTO_SETTING = 8'h37;
    localparam logic [7:0] FULL_SCALE = 8'hFF;
    localparam logic [3:0] DIGIT_DEFAULT = 4'h5;
    localparam logic [3:0] DIGIT_SPAN = 4'hA;
    localparam int unsigned SCALE_SHIFT = 3;

    typedef struct packed {
        logic [7:0] volt_ref;
        logic [7:0] samp_cfg;
        logic [7:0] special;
        logic [7:0] pi_set;
        logic [7:0] ext_time;
    } mpe_cfg_s;

    typedef enum logic [1:0] {
        ST_DRIVE = 2'b01,
        ST_SAMPLE = 2'b10
    } mpe_state_e;

    // Scale in eighths: digit 5 (or 0) is unity, lower digits shrink, higher digits grow.
    function automatic logic [4:0] mpe_digit_scale(input logic [3:0] d);
        case (d)
            4'h1: mpe_digit_scale = 5'h04;
            4'h2: mpe_digit_scale = 5'h05;
            4'h3: mpe_digit_scale = 5'h06;
            4'h4: mpe_digit_scale = 5'h07;
            4'h6: mpe_digit_scale = 5'h0A;
            4'h7: mpe_digit_scale = 5'h0C;
            4'h8: mpe_digit_scale = 5'h0E;
            4'h9: mpe_digit_scale = 5'h10;
            default: mpe_digit_scale = 5'h08;
        endcase
    endfunction : mpe_digit_scale

endpackage : mpe_pkg

// [test/mpe_motor_model.sv]
// Behavioural motor and rectified track supply beyond the drive pin.
`timescale 1ns/10ps
module mpe_motor_model (
    input wire logic sys_clk_i,
    input wire logic rst_n_i,
    input wire logic drive_i,
    input wire logic [7:0] supply_set_i,
    output logic [7:0] supply_volt_o,
    output logic [7:0] back_volt_o
);
    // A driven motor speeds up; a coasting one holds its generated voltage.
    always_ff @(posedge sys_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            supply_volt_o <= 8'h00;
            back_volt_o <= 8'h00;
        end
        else
        begin
            supply_volt_o <= supply_set_i;
            back_volt_o <= back_volt_o + {7'h00, drive_i};
        end
    end
endmodule : mpe_motor_model

// [test/mpe_motor_pwm_props.sv]
// Port-level assertions for the motor PWM and back-voltage sampling block.
`timescale 1ns/10ps
module mpe_motor_pwm_props #(
    parameter int unsigned SAMP_FAST_CYC = 400,
    parameter int unsigned SAMP_SLOW_CYC = 1600
) (
    input wire logic sys_clk_i,
    input wire logic rst_n_i,
    input wire logic [2:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic [7:0] speed_i,
    input wire logic [7:0] motor_back_voltage_i,
    input wire logic motor_pwm_o,
    input wire logic sample_window_o,
    input wire logic [7:0] motor_back_voltage_o,
    input wire logic sample_valid_o,
    input wire logic coreless_o,
    input wire logic auto_tune_o
);
    // ----------------------------------------------------------------
    // Shadow of the PI setting and window length counter
    // ----------------------------------------------------------------
    logic [7:0] pi_r;
    logic [7:0] pi_nxt;
    logic [15:0] win_r;
    logic [15:0] win_nxt;
    logic [31:0] gap_r;
    logic [31:0] gap_nxt;
    always_comb
    begin
        pi_nxt = pi_r;
        if (reg_wr_i && reg_addr_i == mpe_pkg::IDX_PI_SET)
        begin
            pi_nxt = reg_wdata_i;
        end
        win_nxt = sample_window_o ? win_r + 16'h0001 : 16'h0000;
        gap_nxt = (sample_window_o && win_r == 16'h0000) ? 32'h00000000 : gap_r + 32'h00000001;
    end
    always_ff @(posedge sys_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            pi_r <= mpe_pkg::RST_PI_SET;
            win_r <= 16'h0000;
            gap_r <= 32'h00000000;
        end
        else
        begin
            pi_r <= pi_nxt;
            win_r <= win_nxt;
            gap_r <= gap_nxt;
        end
    end
    default clocking cb @(posedge sys_clk_i);
    endclocking
    default disable iff (!rst_n_i);
    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    chk_pwm_off_window:
    assert property (sample_window_o |-> !motor_pwm_o)
        else $error("drive active inside sample window");
    chk_capture_value:
    assert property ($fell(sample_window_o) |-> sample_valid_o &&
        motor_back_voltage_o == $past(motor_back_voltage_i))
        else $error("sample not taken in last window cycle");
    chk_valid_single:
    assert property (sample_valid_o |=> !sample_valid_o)
        else $error("sample valid longer than one cycle");
    chk_valid_cause:
    assert property (sample_valid_o |-> $fell(sample_window_o))
        else $error("sample valid without window end");
    // The longest window is 4000 base cycles plus 255 extended units.
    chk_window_bound:
    assert property (win_r <= 16'h733C)
        else $error("sample window too long");
    chk_idle_off:
    assert property ($past(speed_i) == 8'h00 && $past(speed_i, 2) == 8'h00 |-> !motor_pwm_o)
        else $error("drive active at zero speed");
    chk_coreless_map:
    assert property ($stable(pi_r) |-> coreless_o == (pi_r >= 8'h64 && pi_r <= 8'hC7))
        else $error("coreless flag wrong");
    chk_auto_tune_map:
    // Coreless setting 155 keeps medium gains, so it tunes itself as well.
    assert property ($stable(pi_r) |-> auto_tune_o ==
        (pi_r == 8'h37 || pi_r == 8'h9B || pi_r > 8'hC7))
        else $error("auto tune flag wrong");
    chk_rate_ceiling:
    assert property (gap_r <= 32'(SAMP_SLOW_CYC))
        else $error("sampling interval too long");
endmodule : mpe_motor_pwm_props

// [test/mpe_motor_pwm_tb.sv]
// Self-checking bench for the motor PWM and back-voltage sampling block.
`timescale 1ns/10ps
module mpe_motor_pwm_tb;
    // Short sampling intervals keep the run small; windows stay shorter.
    localparam int unsigned FAST = 2500;
    localparam int unsigned SLOW = 10150;
    logic sys_clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic [2:0] addr = 3'h0;
    logic [7:0] wdata = 8'h00;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [7:0] speed = 8'h00;
    logic [7:0] sup_set = 8'hC8;
    logic [7:0] rdata, supply, bvolt, bv_out;
    logic pwm, win, valid, coreless, auto_t;
    logic [3:0] p_g, i_g;
    int n_mismatch = 0;
    int total_checks = 0;
    int hi, per, w, sp;
    logic [7:0] bv;
    logic [7:0] rst_tbl [5] = '{8'h00, 8'h37, 8'h04, 8'h37, 8'h00};
    logic [7:0] pi_v [7] = '{8'h37, 8'h21, 8'h85, 8'h5B, 8'h6F, 8'h49, 8'h9B};
    logic [15:0] pi_x [7] = '{{6'h00, 4'h5, 4'h5, 2'b01}, {6'h00, 4'h3, 4'h3, 2'b00},
        {6'h00, 4'h3, 4'h3, 2'b10}, {6'h00, 4'h9, 4'h1, 2'b00},
        {6'h00, 4'h1, 4'h1, 2'b10}, {6'h00, 4'h7, 4'h3, 2'b00},
        {6'h00, 4'h5, 4'h5, 2'b11}};
    always #50 sys_clk_i = ~sys_clk_i;
    mpe_motor_pwm #(.SAMP_FAST_CYC(FAST), .SAMP_SLOW_CYC(SLOW)) DUT (
        .sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .reg_addr_i(addr),
        .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata),
        .speed_i(speed), .supply_volt_i(supply), .motor_back_voltage_i(bvolt),
        .motor_pwm_o(pwm), .sample_window_o(win), .motor_back_voltage_o(bv_out),
        .sample_valid_o(valid), .p_gain_o(p_g), .i_gain_o(i_g),
        .coreless_o(coreless), .auto_tune_o(auto_t));
    mpe_motor_model u_motor (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .drive_i(pwm),
        .supply_set_i(sup_set), .supply_volt_o(supply), .back_volt_o(bvolt));
    // ----------------------------------------------------------------
    // Tasks
    // ----------------------------------------------------------------
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0)
        begin
            $display("TB: PASS");
        end
        else
        begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : wrap_up
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("BAD t=%0t got=%0h exp=%0h", $time, got, exp);
        end
    endtask : chk
    task automatic reg_write(input logic [2:0] a, input logic [7:0] d);
        @(posedge sys_clk_i);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge sys_clk_i);
        wr <= 1'b0;
    endtask : reg_write
    task automatic reg_check(input logic [2:0] a, input logic [7:0] e);
        @(posedge sys_clk_i);
        addr <= a;
        rd <= 1'b1;
        @(posedge sys_clk_i);
        rd <= 1'b0;
        #1;
        chk({8'h00, rdata}, {8'h00, e});
    endtask : reg_check
    // Counts settled cycles while the chosen output holds lvl; bounded.
    task automatic span(input bit sel, input logic lvl, output int n);
        n = 0;
        while ((sel ? pwm : win) === lvl)
        begin
            @(posedge sys_clk_i);
            #1;
            n++;
            if (n > 40000)
            begin
                n_mismatch++;
                wrap_up();
            end
        end
    endtask : span
    // One window is skipped so that new settings are in force when measuring.
    task automatic measure(output int wl, output int spc);
        int n;
        int d;
        @(posedge sys_clk_i);
        #1;
        span(0, 1'b1, n);
        span(0, 1'b0, n);
        span(0, 1'b1, wl);
        span(0, 1'b0, d);
        spc = wl + d;
    endtask : measure
    task automatic pwm_meas(output int h, output int p);
        int n;
        int l;
        @(posedge sys_clk_i);
        #1;
        span(0, 1'b0, n);
        span(0, 1'b1, n);
        span(1, 1'b1, n);
        span(1, 1'b0, n);
        span(1, 1'b1, h);
        span(1, 1'b0, l);
        p = h + l;
    endtask : pwm_meas
    function automatic int hi_exp(int spd, int rv, int sv, int pp);
        return (spd * rv * pp + sv * 255 - 1) / (sv * 255);
    endfunction : hi_exp
    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial
    begin
        repeat (10) @(posedge sys_clk_i);
        rst_n_i <= 1'b1;
        foreach (rst_tbl[i]) reg_check(3'(i), rst_tbl[i]);
        foreach (rst_tbl[i])
        begin
            reg_write(3'(i), 8'hA0 + 8'(i));
            reg_check(3'(i), 8'hA0 + 8'(i));
        end
        reg_write(3'h7, 8'hFF);
        reg_check(3'h7, 8'h00);
        foreach (rst_tbl[i]) reg_write(3'(i), rst_tbl[i]);
        foreach (pi_v[i])
        begin
            reg_write(mpe_pkg::IDX_PI_SET, pi_v[i]);
            repeat (2) @(posedge sys_clk_i);
            #1;
            chk({6'h00, p_g, i_g, coreless, auto_t}, pi_x[i]);
        end
        reg_write(mpe_pkg::IDX_PI_SET, 8'h37);
        speed <= 8'h80;
        pwm_meas(hi, per);
        chk(16'(per), 16'd500);
        chk(16'(hi), 16'(hi_exp(128, 200, 200, 500)));
        reg_write(mpe_pkg::IDX_SPECIAL, 8'h24);
        pwm_meas(hi, per);
        chk(16'(per), 16'd250);
        chk(16'(hi), 16'(hi_exp(128, 200, 200, 250)));
        reg_write(mpe_pkg::IDX_SPECIAL, 8'h04);
        reg_write(mpe_pkg::IDX_VOLT_REF, 8'h64);
        sup_set <= 8'h96;
        pwm_meas(hi, per);
        chk(16'(hi), 16'(hi_exp(128, 100, 150, 500)));
        reg_write(mpe_pkg::IDX_VOLT_REF, 8'h00);
        speed <= 8'h00;
        measure(w, sp);
        chk(16'(sp), 16'(FAST));
        chk(16'(w), 16'd2000);
        reg_write(mpe_pkg::IDX_SAMP_CFG, 8'h0B);
        reg_write(mpe_pkg::IDX_EXT_TIME, 8'h14);
        measure(w, sp);
        chk(16'(sp), 16'(FAST * 16 / 8));
        chk(16'(w), 16'(2000 * 4 / 8 + 20 * 100));
        reg_write(mpe_pkg::IDX_SAMP_CFG, 8'h37);
        reg_write(mpe_pkg::IDX_EXT_TIME, 8'h00);
        speed <= 8'hFF;
        measure(w, sp);
        chk(16'(sp), 16'(SLOW));
        reg_write(mpe_pkg::IDX_SAMP_CFG, 8'h63);
        measure(w, sp);
        chk(16'(sp), 16'(SLOW * 4 / 8));
        chk(16'(w), 16'(2000 * 16 / 8));
        // A low-frequency period is seen by stretching one fast pulse inside a long drive phase.
        reg_write(mpe_pkg::IDX_SAMP_CFG, 8'h37);
        reg_write(mpe_pkg::IDX_VOLT_REF, 8'h01);
        #1;
        span(0, 1'b0, w);
        span(0, 1'b1, w);
        bv = bvolt;
        span(1, 1'b1, w);
        span(1, 1'b0, w);
        reg_write(mpe_pkg::IDX_SAMP_CFG, 8'hB2);
        #1;
        span(1, 1'b1, hi);
        chk(16'(hi), 16'(hi_exp(255, 1, 150, (131 + 4 * 18) * 32 * 10) - 2));
        reg_check(mpe_pkg::IDX_BACK_VOLT, bv);
        reg_check(mpe_pkg::IDX_STATUS, 8'h01);
        wrap_up();
    end
endmodule : mpe_motor_pwm_tb
bind mpe_motor_pwm mpe_motor_pwm_props #(
    .SAMP_FAST_CYC(SAMP_FAST_CYC),
    .SAMP_SLOW_CYC(SAMP_SLOW_CYC)
) u_props (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .speed_i(speed_i),
    .motor_back_voltage_i(motor_back_voltage_i), .motor_pwm_o(motor_pwm_o),
    .sample_window_o(sample_window_o), .motor_back_voltage_o(motor_back_voltage_o),
    .sample_valid_o(sample_valid_o), .coreless_o(coreless_o), .auto_tune_o(auto_tune_o));
